// [gateway_pkg.sv]
// Shared constants, types and state encodings of the fieldbus gateway block
package gateway_pkg;

  // Buffer capacity in bytes, one per direction
  localparam int BUF_BYTES = 1024;
  // User data bytes carried per fieldbus cycle
  localparam int DEF_DATA_BYTES = 8;

  // Timing: telegram gap and reset-pattern hold time
  localparam int CLK_HZ     = 200_000_000;
  localparam int GAP_MS     = 20;
  localparam int GAP_CYCLES = GAP_MS * (CLK_HZ / 1000);

  // Fieldbus output image bit positions
  localparam int CTRL0_CMD_BIT  = 0;
  localparam int CTRL0_ND_BIT   = 7;
  localparam int CTRL1_RACK_BIT = 0;
  localparam int CTRL1_SFB_BIT  = 2;
  localparam int CTRL1_CTB_BIT  = 3;

  // Byte values
  localparam logic [7:0] RESET_PATTERN = 8'haa;
  localparam logic [7:0] END_BYTE      = 8'h00;
  localparam logic [7:0] CTRL_LIMIT    = 8'h20;

  // APB register byte addresses
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_LEVELS = 12'h008;

  // Config register fields and reset values
  localparam int         CFG_COLL_BIT   = 0;
  localparam int         CFG_LEN_LSB    = 8;
  localparam logic       COLL_RESET     = 1'b0;
  localparam logic [7:0] TEL_LEN_RESET  = 8'h08;

  // Status byte 0 towards the fieldbus master
  typedef struct packed {
    logic fresh_set_toggle;
    logic buffer_overflow_flag;
    logic [1:0] unused_hi;
    logic rx_pending_flag;
    logic unused_mid;
    logic block_delivered_toggle;
    logic unused_lo;
  } in_status_t;

  // Transmit side sequencer
  typedef enum logic [3:0] {
    TX_IDLE   = 4'b0001,
    TX_APPEND = 4'b0010,
    TX_DIRECT = 4'b0100,
    TX_FLUSH  = 4'b1000
  } tx_state_t;

  // Receive block loader
  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_LOAD = 2'b10
  } rx_state_t;

endpackage

// [fieldbus_serial_gateway_exchange.sv]
// Data-exchange core between a fieldbus image and a serial end device
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Collective: read-acknowledge change loads next buffered block, flips delivered toggle
// - Collective: read-acknowledge change with empty buffer clears input image to zero
// - Flush toggle change sends whole transmit buffer in arrival order
// - Append toggle change copies output data into transmit buffer
// - New data without append or flush toggle goes straight out, telegram length
// - AA pattern held over 20 ms clears buffers and status
// - Transparent and Collective modes, Transparent after reset
// - Transparent passes one cycle worth of bytes, rest dropped
// - Telegrams separated by more than 20 ms idle gap
// - Transparent cuts telegram at zero byte, strips control characters
// - Collective buffers serial data and raises pending flag
// - Collective keeps framing characters in the delivered data
// - Collective buffer holds one kilobyte
// - Overflow flag set on overflow, clears with space; RTS dropped
// - Input byte 1 reports user byte count of the block
// - Command mode forwards no master data to the serial device
module fieldbus_serial_gateway_exchange #(
  parameter int DATA_BYTES = gateway_pkg::DEF_DATA_BYTES,
  parameter int BUF_DEPTH  = gateway_pkg::BUF_BYTES,
  parameter int GAP_CYCLES = gateway_pkg::GAP_CYCLES
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic [11:0]                 paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Fieldbus output image from the master
  input  wire logic                        fb_cycle,
  input  wire logic [7:0]                  fb_ctrl0,
  input  wire logic [7:0]                  fb_ctrl1,
  input  wire logic [DATA_BYTES-1:0][7:0]  fb_out_data,
  output logic                             fb_busy,
  // Fieldbus input image to the master
  output gateway_pkg::in_status_t          fb_in_status,
  output logic      [7:0]                  fb_in_count,
  output logic      [DATA_BYTES-1:0][7:0]  fb_in_data,
  // Serial device side
  output logic      [7:0]                  ser_tx_data,
  output logic                             ser_tx_valid,
  input  wire logic                        ser_tx_ready,
  input  wire logic [7:0]                  ser_rx_data,
  input  wire logic                        ser_rx_valid,
  output logic                             ser_rts
);

  localparam int AW = $clog2(BUF_DEPTH);
  localparam logic [AW:0] DEPTH_W = (AW + 1)'(BUF_DEPTH);
  localparam logic [7:0]  DB8     = 8'(DATA_BYTES);
  localparam logic [31:0] GAP_W   = 32'(GAP_CYCLES);

  // Refuse shapes the pointers and count byte cannot serve
  if (DATA_BYTES < 2 || DATA_BYTES > 255 ||
      BUF_DEPTH < 2 || (1 << AW) != BUF_DEPTH || GAP_CYCLES < 1)
  begin : g_check
    $error("gateway parameters out of range");
  end

  typedef struct packed {
    gateway_pkg::tx_state_t  tx;
    gateway_pkg::rx_state_t  rx;
    logic [DATA_BYTES-1:0][7:0] odata;
    logic                    prev_nd;
    logic                    prev_rack;
    logic                    prev_sfb;
    logic                    prev_ctb;
    logic                    sfb_pend;
    logic [AW:0]             tx_wr;
    logic [AW:0]             tx_rd;
    logic [AW:0]             rx_wr;
    logic [AW:0]             rx_rd;
    logic [7:0]              idx;
    logic [7:0]              tx_byte;
    logic                    tx_valid;
    gateway_pkg::in_status_t st;
    logic [7:0]              count;
    logic [DATA_BYTES-1:0][7:0] idata;
    logic [DATA_BYTES-1:0][7:0] stage;
    logic [7:0]              stage_cnt;
    logic                    stage_cut;
    logic [31:0]             gap_cnt;
    logic [31:0]             pat_cnt;
    logic                    collective;
    logic [7:0]              tel_len;
    logic [31:0]             rdata;
    logic                    rd_err;
  } state_t;

  state_t s;
  state_t next_s;

  // Byte memories, one per direction
  logic [7:0]    tx_mem [BUF_DEPTH];
  logic [7:0]    rx_mem [BUF_DEPTH];
  logic          tx_we;
  logic          rx_we;
  logic [7:0]    tx_rdata;
  logic [7:0]    rx_rdata;
  logic [AW:0]   tx_level;
  logic [AW:0]   rx_level;
  logic [7:0]    eff_len;
  logic          pattern_now;
  logic          clear_all;
  logic          ovf_evt;
  logic          fb_take;
  logic          addr_ok;

  assign tx_rdata = tx_mem[s.tx_rd[AW-1:0]];
  assign rx_rdata = rx_mem[s.rx_rd[AW-1:0]];
  assign tx_level = s.tx_wr - s.tx_rd;
  assign rx_level = s.rx_wr - s.rx_rd;
  assign eff_len  = (s.tel_len > DB8) ? DB8 : s.tel_len;
  assign fb_busy  = (s.tx != gateway_pkg::TX_IDLE) ||
                    (s.rx != gateway_pkg::RX_IDLE);
  assign fb_take  = fb_cycle && !fb_busy;
  assign addr_ok  = (paddr == gateway_pkg::ADDR_CONFIG) ||
                    (paddr == gateway_pkg::ADDR_STATUS) ||
                    (paddr == gateway_pkg::ADDR_LEVELS);
  assign pattern_now = (s.odata[0] == gateway_pkg::RESET_PATTERN) &&
                       (s.odata[1] == gateway_pkg::RESET_PATTERN) &&
                       (s.prev_nd && s.prev_ctb == 1'b1 && !s.prev_sfb) &&
                       (s.prev_rack == 1'b0);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    next_s  = s;
    tx_we   = 1'b0;
    rx_we   = 1'b0;
    ovf_evt = 1'b0;
    clear_all = 1'b0;

    // APB: read data captured in setup, writes land in the access phase
    if (psel && !penable)
    begin
      next_s.rd_err = !addr_ok;
      unique case (paddr)
        gateway_pkg::ADDR_CONFIG: next_s.rdata =
          {16'h0000, s.tel_len, 7'h00, s.collective};
        gateway_pkg::ADDR_STATUS: next_s.rdata =
          {14'h0000, s.tx_valid, fb_busy, s.count, s.st};
        gateway_pkg::ADDR_LEVELS: next_s.rdata =
          {16'(tx_level), 16'(rx_level)};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite && paddr == gateway_pkg::ADDR_CONFIG)
    begin
      next_s.collective = pwdata[gateway_pkg::CFG_COLL_BIT];
      next_s.tel_len = pwdata[gateway_pkg::CFG_LEN_LSB +: 8];
    end

    // Incoming fieldbus cycle: compare toggles with the stored copy
    if (fb_take)
    begin
      next_s.odata     = fb_out_data;
      next_s.prev_nd   = fb_ctrl0[gateway_pkg::CTRL0_ND_BIT];
      next_s.prev_rack = fb_ctrl1[gateway_pkg::CTRL1_RACK_BIT];
      next_s.prev_sfb  = fb_ctrl1[gateway_pkg::CTRL1_SFB_BIT];
      next_s.prev_ctb  = fb_ctrl1[gateway_pkg::CTRL1_CTB_BIT];
      if (s.collective &&
          (fb_ctrl1[gateway_pkg::CTRL1_RACK_BIT] != s.prev_rack))
      begin
        next_s.idata = '0;
        next_s.idx   = 8'h00;
        if (rx_level != '0)
          next_s.rx = gateway_pkg::RX_LOAD;
        else
          next_s.count = 8'h00;
      end
      // Command mode keeps all master data off the serial line
      if (!fb_ctrl0[gateway_pkg::CTRL0_CMD_BIT])
      begin
        next_s.idx = 8'h00;
        if (fb_ctrl1[gateway_pkg::CTRL1_CTB_BIT] != s.prev_ctb)
        begin
          next_s.tx = gateway_pkg::TX_APPEND;
          next_s.sfb_pend =
            fb_ctrl1[gateway_pkg::CTRL1_SFB_BIT] != s.prev_sfb;
        end
        else if (fb_ctrl1[gateway_pkg::CTRL1_SFB_BIT] != s.prev_sfb)
          next_s.tx = gateway_pkg::TX_FLUSH;
        else if (fb_ctrl0[gateway_pkg::CTRL0_ND_BIT] != s.prev_nd)
          next_s.tx = gateway_pkg::TX_DIRECT;
      end
    end

    // Transmit sequencer; a byte is offered until the device takes it
    unique case (s.tx)
      gateway_pkg::TX_IDLE: ;
      gateway_pkg::TX_APPEND:
        if (s.idx < eff_len)
        begin
          if (tx_level == DEPTH_W)
            ovf_evt = 1'b1;
          else
          begin
            tx_we = 1'b1;
            next_s.tx_wr = s.tx_wr + 1'b1;
          end
          next_s.idx = s.idx + 8'h01;
        end
        else
        begin
          next_s.tx = s.sfb_pend ? gateway_pkg::TX_FLUSH
                                 : gateway_pkg::TX_IDLE;
          next_s.sfb_pend = 1'b0;
        end
      gateway_pkg::TX_DIRECT:
        if (!s.tx_valid || ser_tx_ready)
        begin
          if (s.idx < eff_len)
          begin
            next_s.tx_byte  = s.odata[s.idx];
            next_s.tx_valid = 1'b1;
            next_s.idx = s.idx + 8'h01;
          end
          else
          begin
            next_s.tx_valid = 1'b0;
            next_s.tx = gateway_pkg::TX_IDLE;
          end
        end
      gateway_pkg::TX_FLUSH:
        if (!s.tx_valid || ser_tx_ready)
        begin
          if (s.tx_rd != s.tx_wr)
          begin
            next_s.tx_byte  = tx_rdata;
            next_s.tx_valid = 1'b1;
            next_s.tx_rd = s.tx_rd + 1'b1;
          end
          else
          begin
            next_s.tx_valid = 1'b0;
            next_s.tx_rd = '0;
            next_s.tx_wr = '0;
            next_s.tx = gateway_pkg::TX_IDLE;
          end
        end
      default: next_s.tx = gateway_pkg::TX_IDLE;
    endcase

    // Collective receive: every byte, framing included, is buffered unless the buffer is full
    if (s.collective && ser_rx_valid)
    begin
      if (rx_level == DEPTH_W)
        ovf_evt = 1'b1;
      else
      begin
        rx_we = 1'b1;
        next_s.rx_wr = s.rx_wr + 1'b1;
      end
    end

    // Block loader: one buffered byte per clock into the input image
    unique case (s.rx)
      gateway_pkg::RX_IDLE: ;
      gateway_pkg::RX_LOAD:
        if (s.rx_rd != s.rx_wr && s.idx < DB8)
        begin
          next_s.idata[s.idx] = rx_rdata;
          next_s.rx_rd = s.rx_rd + 1'b1;
          next_s.idx = s.idx + 8'h01;
        end
        else
        begin
          next_s.count = s.idx;
          next_s.st.block_delivered_toggle =
            !s.st.block_delivered_toggle;
          next_s.rx = gateway_pkg::RX_IDLE;
        end
      default: next_s.rx = gateway_pkg::RX_IDLE;
    endcase

    // Transparent receive: stage one cycle of bytes, close on idle gap
    if (!s.collective && ser_rx_valid)
    begin
      next_s.gap_cnt = 32'h0000_0000;
      if (!s.stage_cut)
      begin
        if (ser_rx_data == gateway_pkg::END_BYTE)
          next_s.stage_cut = 1'b1;
        else if (ser_rx_data >= gateway_pkg::CTRL_LIMIT &&
                 s.stage_cnt < DB8)
        begin
          next_s.stage[s.stage_cnt] = ser_rx_data;
          next_s.stage_cnt = s.stage_cnt + 8'h01;
        end
      end
    end
    else if (s.gap_cnt <= GAP_W)
    begin
      next_s.gap_cnt = s.gap_cnt + 32'h0000_0001;
      if (s.gap_cnt == GAP_W)
      begin
        if (s.stage_cnt != 8'h00 && !s.collective)
        begin
          next_s.idata = s.stage;
          next_s.count = s.stage_cnt;
          next_s.st.fresh_set_toggle = !s.st.fresh_set_toggle;
        end
        next_s.stage = '0;
        next_s.stage_cnt = 8'h00;
        next_s.stage_cut = 1'b0;
      end
    end

    // Overflow: set wins, clears once both buffers have room
    next_s.st.buffer_overflow_flag = ovf_evt ||
      (s.st.buffer_overflow_flag &&
       (rx_level == DEPTH_W || tx_level == DEPTH_W));
    next_s.st.rx_pending_flag = (next_s.rx_wr != next_s.rx_rd);

    // Reset pattern must stand over the gap time before it acts
    if (pattern_now && fb_ctrl0 == gateway_pkg::RESET_PATTERN &&
        fb_ctrl1 == gateway_pkg::RESET_PATTERN)
    begin
      if (s.pat_cnt <= GAP_W)
        next_s.pat_cnt = s.pat_cnt + 32'h0000_0001;
      clear_all = (s.pat_cnt == GAP_W);
    end
    else
      next_s.pat_cnt = 32'h0000_0000;
    if (clear_all)
    begin
      next_s.tx = gateway_pkg::TX_IDLE;
      next_s.rx = gateway_pkg::RX_IDLE;
      next_s.tx_wr = '0;
      next_s.tx_rd = '0;
      next_s.rx_wr = '0;
      next_s.rx_rd = '0;
      next_s.st = '0;
      next_s.count = 8'h00;
      next_s.idata = '0;
      next_s.stage = '0;
      next_s.stage_cnt = 8'h00;
      next_s.stage_cut = 1'b0;
      next_s.tx_valid = 1'b0;
      next_s.sfb_pend = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.tx <= gateway_pkg::TX_IDLE;
      s.rx <= gateway_pkg::RX_IDLE;
      s.collective <= gateway_pkg::COLL_RESET;
      s.tel_len <= gateway_pkg::TEL_LEN_RESET;
    end
    else
      s <= next_s;
  end

  // Memory writes; contents need no reset since pointers gate reads
  always_ff @(posedge pclk)
  begin
    if (tx_we)
      tx_mem[s.tx_wr[AW-1:0]] <= s.odata[s.idx];
    if (rx_we)
      rx_mem[s.rx_wr[AW-1:0]] <= ser_rx_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata       = s.rdata;
  assign pready       = 1'b1;
  assign pslverr      = s.rd_err && psel && penable;
  assign fb_in_status = s.st;
  assign fb_in_count  = s.count;
  assign fb_in_data   = s.idata;
  assign ser_tx_data  = s.tx_byte;
  assign ser_tx_valid = s.tx_valid;
  assign ser_rts      = !s.st.buffer_overflow_flag;

endmodule

`default_nettype wire

// [serial_dev_model.sv]
// Serial end device model facing the gateway serial side
`timescale 1ns/1ps
`default_nettype none
module serial_dev_model #(
  parameter int GAP = 50
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bytes from the gateway
  input  wire logic [7:0] ser_tx_data,
  input  wire logic       ser_tx_valid,
  output logic            ser_tx_ready,
  input  wire logic       slow,
  // Bytes to the gateway
  output logic [7:0]      ser_rx_data,
  output logic            ser_rx_valid
);
  logic [7:0] got[$];

  // Idle levels at time zero
  initial
  begin
    ser_tx_ready = 1'b0;
    ser_rx_data  = 8'h00;
    ser_rx_valid = 1'b0;
  end

  // Accept at ready and valid; slow mode stalls every other cycle
  always @(posedge pclk)
  begin
    if (presetn && ser_tx_valid && ser_tx_ready)
      got.push_back(ser_tx_data);
    ser_tx_ready <= presetn && (slow ? ~ser_tx_ready : 1'b1);
  end

  // One telegram back to back, then a gap past the delimiter time
  task automatic send_tel(input logic [7:0] b[$]);
    foreach (b[i])
    begin
      @(posedge pclk);
      ser_rx_valid <= 1'b1;
      ser_rx_data  <= b[i];
    end
    @(posedge pclk);
    ser_rx_valid <= 1'b0;
    ser_rx_data  <= ~b[b.size()-1]; // Stale data never looks valid
    repeat (GAP + 10) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// [gateway_monitor.sv]
// Port-level assertions for the gateway exchange core
`timescale 1ns/1ps
`default_nettype none
module gateway_monitor #(
  parameter int DATA_BYTES = 8
) (
  // Clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // APB
  input wire logic [11:0]                paddr,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // Fieldbus image
  input wire logic                       fb_cycle,
  input wire logic [7:0]                 fb_ctrl0,
  input wire logic [7:0]                 fb_ctrl1,
  input wire logic [DATA_BYTES-1:0][7:0] fb_out_data,
  input wire logic                       fb_busy,
  input wire gateway_pkg::in_status_t    fb_in_status,
  input wire logic [7:0]                 fb_in_count,
  // Serial side
  input wire logic [7:0]                 ser_tx_data,
  input wire logic                       ser_tx_valid,
  input wire logic                       ser_tx_ready,
  input wire logic                       ser_rts
);
  logic      [7:0] lc0;
  logic      [7:0] lc1;
  wire logic       taken = fb_cycle && !fb_busy;
  wire logic [7:0] d0    = fb_ctrl0 ^ lc0;
  wire logic [7:0] d1    = fb_ctrl1 ^ lc1;

  // Toggles of the last taken image; a refused image must not count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lc0 <= 8'h00;
      lc1 <= 8'h00;
    end
    else if (taken)
    begin
      lc0 <= fb_ctrl0;
      lc1 <= fb_ctrl1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_direct;
    taken && !fb_ctrl0[0] && d0[7] && d1[3:0] == 4'h0;
  endsequence
  sequence s_quiet;
    taken && !d0[7] && d1[3:0] == 4'h0 && !ser_tx_valid;
  endsequence

  a_pready_high: assert property (pready)
    else $error("pready low");
  a_map_error: assert property (psel && penable |->
    pslverr == (paddr[1:0] != 2'h0 || paddr > gateway_pkg::ADDR_LEVELS))
    else $error("slave error does not match address map");
  a_prdata_holds: assert property ($changed(prdata) |->
    $past(psel && !penable))
    else $error("read data changed outside setup");
  a_rts_ovf: assert property (ser_rts == !fb_in_status.buffer_overflow_flag)
    else $error("rts does not follow overflow flag");
  a_tx_hold: assert property (ser_tx_valid && !ser_tx_ready |=>
    ser_tx_valid && $stable(ser_tx_data))
    else $error("serial byte dropped before accept");
  a_direct_first: assert property (s_direct |-> ##2
    ser_tx_valid && ser_tx_data == $past(fb_out_data[0], 2))
    else $error("direct send did not start with byte 0");
  a_quiet_idle: assert property (s_quiet |=> !ser_tx_valid [*3])
    else $error("serial traffic without toggle change");
  a_cmd_blocks: assert property (taken && fb_ctrl0[0] && !ser_tx_valid
    |=> !ser_tx_valid [*3])
    else $error("serial traffic in command mode");
  a_append_silent: assert property (taken && !fb_ctrl0[0] && d1[3] &&
    !d1[2] && !ser_tx_valid |=> !ser_tx_valid [*3])
    else $error("append sent data out");
  a_count_bound: assert property (fb_in_count <= DATA_BYTES)
    else $error("byte count beyond one cycle");
endmodule

bind fieldbus_serial_gateway_exchange gateway_monitor #(
  .DATA_BYTES(DATA_BYTES)
) u_gateway_monitor (
  .pclk, .presetn, .paddr, .psel, .penable, .prdata, .pready, .pslverr,
  .fb_cycle, .fb_ctrl0, .fb_ctrl1, .fb_out_data, .fb_busy, .fb_in_status,
  .fb_in_count, .ser_tx_data, .ser_tx_valid, .ser_tx_ready, .ser_rts
);
`default_nettype wire

// [fieldbus_serial_gateway_exchange_tb.sv]
// Self-checking bench for the gateway exchange core
`timescale 1ns/1ps
`default_nettype none
module fieldbus_serial_gateway_exchange_tb;
  localparam int NB  = 4;
  localparam int GAP = 50;
  logic                    pclk        = 1'b0;
  logic                    presetn     = 1'b0;
  logic [11:0]             paddr       = 12'h000;
  logic                    psel        = 1'b0;
  logic                    penable     = 1'b0;
  logic                    pwrite      = 1'b0;
  logic [31:0]             pwdata      = 32'h0;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    fb_cycle    = 1'b0;
  logic [7:0]              fb_ctrl0    = 8'h00;
  logic [7:0]              fb_ctrl1    = 8'h00;
  logic [NB-1:0][7:0]      fb_out_data = '0;
  logic                    fb_busy;
  gateway_pkg::in_status_t fb_in_status;
  logic [7:0]              fb_in_count;
  logic [NB-1:0][7:0]      fb_in_data;
  logic [7:0]              ser_tx_data;
  logic                    ser_tx_valid;
  logic                    ser_tx_ready;
  logic [7:0]              ser_rx_data;
  logic                    ser_rx_valid;
  logic                    ser_rts;
  logic                    slow        = 1'b0;
  int                      n_errors    = 0;
  int                      checks_done = 0;
  logic [7:0]              c0          = 8'h00;
  logic [7:0]              c1          = 8'h00;
  logic [7:0]              seed        = 8'h43;
  logic [7:0]              exp_q[$];
  logic [7:0]              rxq[$];
  logic [31:0]             r;
  logic                    err;
  logic                    fs          = 1'b0;
  logic                    bl          = 1'b0;

  fieldbus_serial_gateway_exchange #(
    .DATA_BYTES(NB), .BUF_DEPTH(8), .GAP_CYCLES(GAP)
  ) u_fieldbus_serial_gateway_exchange (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .fb_cycle, .fb_ctrl0, .fb_ctrl1, .fb_out_data,
    .fb_busy, .fb_in_status, .fb_in_count, .fb_in_data, .ser_tx_data,
    .ser_tx_valid, .ser_tx_ready, .ser_rx_data, .ser_rx_valid, .ser_rts
  );
  serial_dev_model #(.GAP(GAP)) u_serial_dev_model (
    .pclk, .presetn, .ser_tx_data, .ser_tx_valid, .ser_tx_ready, .slow,
    .ser_rx_data, .ser_rx_valid
  );
  ////////////////////////////////////////////////////////////////////////
  // Clock and a watchdog far beyond the expected run
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end
  initial
  begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    close_out();
  end

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    checks_done++;
    if (v !== e)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, v, e);
    end
  endtask
  // APB master: request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Busy is sampled mid-cycle so a refused image is never sent
  task automatic idle();
    repeat (2) @(negedge pclk);
    while (fb_busy !== 1'b0)
      @(negedge pclk);
  endtask
  task automatic fb(input logic [NB-1:0][7:0] d);
    idle();
    @(posedge pclk);
    fb_ctrl0    <= c0;
    fb_ctrl1    <= c1;
    fb_out_data <= d;
    fb_cycle    <= 1'b1;
    @(posedge pclk);
    fb_cycle <= 1'b0;
    idle();
  endtask
  task automatic rnd(output logic [NB-1:0][7:0] d);
    for (int i = 0; i < NB; i++)
    begin
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      d[i] = seed;
    end
  endtask
  task automatic push(input logic [NB-1:0][7:0] d);
    for (int i = 0; i < NB; i++)
      exp_q.push_back(d[i]);
  endtask
  // Serial bytes against the expected queue, in order
  task automatic expect_tx();
    int n;
    n = 0;
    while (u_serial_dev_model.got.size() < exp_q.size() && n < 900)
    begin
      @(posedge pclk);
      n++;
    end
    repeat (8) @(posedge pclk);
    chk(32'(u_serial_dev_model.got.size()), 32'(exp_q.size()));
    foreach (exp_q[i])
      if (i < u_serial_dev_model.got.size())
        chk(32'(u_serial_dev_model.got[i]), 32'(exp_q[i]));
    exp_q.delete();
    u_serial_dev_model.got.delete();
  endtask
  // Transparent telegram: zero ends it, control bytes dropped
  task automatic run_tel(input logic [7:0] t[$]);
    logic [NB-1:0][7:0] e;
    int n;
    u_serial_dev_model.send_tel(t);
    e = '0;
    n = 0;
    foreach (t[i])
    begin
      if (t[i] == 8'h00)
        break;
      if (t[i] >= 8'h20 && n < NB)
      begin
        e[n] = t[i];
        n++;
      end
    end
    fs = ~fs;
    chk(32'(fb_in_count), 32'(n));
    chk(32'(fb_in_data), 32'(e));
    chk(32'(fb_in_status.fresh_set_toggle), 32'(fs));
  endtask

  // Main sequence
  initial
  begin
    logic [NB-1:0][7:0] d;
    int n;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(32'(fb_in_status), 32'h0);
    chk(32'(ser_rts), 32'h1);
    apb(1'b0, gateway_pkg::ADDR_CONFIG, 32'h0);
    chk(r, {16'h0, gateway_pkg::TEL_LEN_RESET, 7'h0,
            gateway_pkg::COLL_RESET});
    apb(1'b0, 12'h00c, 32'h0);
    chk({r[30:0], err}, 32'h1);
    $display("test 1 done");
    slow <= 1'b1;
    rnd(d);
    for (int k = 0; k < 2; k++)
    begin
      c0[7] = ~c0[7];
      fb(d);
      push(d);
      expect_tx();
    end
    fb(d);
    expect_tx();
    c0 = c0 ^ 8'h81;
    fb(d);
    expect_tx();
    c0[0] = 1'b0;
    $display("test 2 done");
    for (int k = 0; k < 3; k++)
    begin
      rnd(d);
      c1[3] = ~c1[3];
      fb(d);
      if (k < 2)
        push(d);
    end
    apb(1'b0, gateway_pkg::ADDR_LEVELS, 32'h0);
    chk(32'(r[31:16]), 32'd8);
    chk(32'(u_serial_dev_model.got.size()), 32'd0);
    chk({ser_rts, fb_in_status.buffer_overflow_flag}, 32'h1);
    c1[2] = ~c1[2];
    fb(d);
    expect_tx();
    apb(1'b0, gateway_pkg::ADDR_LEVELS, 32'h0);
    chk(32'(r[31:16]), 32'd0);
    chk({ser_rts, fb_in_status.buffer_overflow_flag}, 32'h2);
    $display("test 3 done");
    apb(1'b1, gateway_pkg::ADDR_CONFIG, 32'h0000_0801);
    rxq = '{8'h02, 8'h41, 8'h42, 8'h43, 8'h0d, 8'h0a};
    u_serial_dev_model.send_tel(rxq);
    chk(32'(fb_in_status.rx_pending_flag), 32'h1);
    apb(1'b0, gateway_pkg::ADDR_LEVELS, 32'h0);
    chk(32'(r[15:0]), 32'd6);
    repeat (3)
    begin
      c1[0] = ~c1[0];
      fb(d);
      n = rxq.size() < NB ? rxq.size() : NB;
      chk(32'(fb_in_count), 32'(n));
      for (int i = 0; i < NB; i++)
        if (i < n)
          chk(32'(fb_in_data[i]), 32'(rxq.pop_front()));
        else if (n == 0)
          chk(32'(fb_in_data[i]), 32'h0);
      bl = bl ^ (n > 0);
      if (n > 0)
        chk(32'(fb_in_status.block_delivered_toggle), 32'(bl));
      chk(32'(fb_in_status.rx_pending_flag), 32'(rxq.size() > 0));
    end
    $display("test 4 done");
    apb(1'b1, gateway_pkg::ADDR_CONFIG, 32'h0000_0800);
    run_tel('{8'h41, 8'h01, 8'h42, 8'h43, 8'h44, 8'h45});
    run_tel('{8'h31, 8'h00, 8'h32});
    $display("test 5 done");
    c1 = 8'h00;
    fb(d);
    push(d);
    expect_tx();
    c0 = 8'haa;
    c1 = 8'haa;
    fb(32'h0000_aaaa);
    apb(1'b0, gateway_pkg::ADDR_LEVELS, 32'h0);
    chk(32'(r[31:16]), 32'd4);
    repeat (GAP + 10) @(posedge pclk);
    apb(1'b0, gateway_pkg::ADDR_LEVELS, 32'h0);
    chk(r, 32'h0);
    chk({fb_in_status, fb_in_count, 16'(fb_in_data)}, 32'h0);
    apb(1'b0, gateway_pkg::ADDR_STATUS, 32'h0);
    chk(r, 32'h0);
    $display("test 6 done");
    close_out();
  end
endmodule
`default_nettype wire
